// ### design/brbf_pkg.sv
// package for the bus receiver buffer flag block
// assumes one clock domain, pclk at 125 MHz, apb register access
package brbf_pkg;
  localparam int brbf_data_w = 12;
  localparam int brbf_addr_w = 6;
  localparam logic [brbf_addr_w-1:0] brbf_sel_code_def = 6'h30;
  // register byte addresses
  localparam logic [7:0] brbf_off_ctrl = 8'h00;
  localparam logic [7:0] brbf_off_stat = 8'h04;
  localparam logic [7:0] brbf_off_buf = 8'h08;
  localparam logic [7:0] brbf_off_ists = 8'h0c;
  localparam logic [7:0] brbf_off_imsk = 8'h10;
  // ctrl fields
  localparam int brbf_ctrl_pie = 0;
  // stat fields
  localparam int brbf_stat_flag = 0;
  localparam int brbf_stat_sel = 1;
  // event bits
  localparam int brbf_ev_w = 3;
  localparam int brbf_ev_set = 0;
  localparam int brbf_ev_load = 1;
  localparam int brbf_ev_skip = 2;
  localparam logic [31:0] brbf_ctrl_rst = 32'h0000_0001;
  typedef struct packed {
    logic [brbf_addr_w-1:0] sel;
    logic iop1;
    logic iop2;
    logic init;
    logic flag_set;
  } brbf_bus_in_t;
endpackage

// ### design/brbf_top.sv
// twelve-bit bus receiver with device selector, flag and buffer register
// assumes io pulses and peripheral set come from outside pclk domain
// io pulses must stay high for more than two pclk periods
//
// What this block does
// [R1] six address lines compared with selection code; match gives select level
// [R2] first io pulse while selected makes internal flag test pulse
// [R3] skip line pulled low through open drain when flag set during test
// [R4] address match acts as option select enabling buffer input gate
// [R5] second io pulse while selected clears flag and loads buffer
// [R6] flag sets on a rising edge at the peripheral set input
// [R7] flag and interrupt enable pull interrupt request line low
// [R8] current flag state shown on a dedicated output
// [R9] flag cleared by second io pulse or by initialize pulse
// [R10] bus data blocked from buffer while device not addressed
// [R11] buffer jam loaded all bits at once, stable until next load
// [R12] buffer register twelve bits wide, holds received bus word
// [R13] host holds selection code stable around each io pulse
// [R14] io pulses without address match change nothing
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
module brbf_top #(
  parameter int data_w = brbf_pkg::brbf_data_w,
  parameter logic [brbf_pkg::brbf_addr_w-1:0] sel_code =
    brbf_pkg::brbf_sel_code_def
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [brbf_pkg::brbf_addr_w-1:0] memory_buffer_bus_lines,
  input wire logic first_io_pulse,
  input wire logic second_io_pulse,
  input wire logic init_pulse,
  input wire logic flag_set_in,
  input wire logic [data_w-1:0] accumulator_output_lines,
  output logic skip_o,
  output logic skip_oe,
  output logic pi_o,
  output logic pi_oe,
  output logic flag_out,
  output logic [data_w-1:0] buffer_out,
  output logic irq
);
  // two-stage synchronisers for pins, delayed copy for edges
  // the third stage only feeds the edge detectors
  brbf_pkg::brbf_bus_in_t s1_q;
  brbf_pkg::brbf_bus_in_t s2_q;
  brbf_pkg::brbf_bus_in_t s3_q;
  brbf_pkg::brbf_bus_in_t s1_d;
  brbf_pkg::brbf_bus_in_t s2_d;
  brbf_pkg::brbf_bus_in_t s3_d;
  logic [data_w-1:0] ac1_q;
  logic [data_w-1:0] ac2_q;
  logic [data_w-1:0] ac1_d;
  logic [data_w-1:0] ac2_d;

  always_comb begin
    s1_d.sel = memory_buffer_bus_lines;
    s1_d.iop1 = first_io_pulse;
    s1_d.iop2 = second_io_pulse;
    s1_d.init = init_pulse;
    s1_d.flag_set = flag_set_in;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // data bits are not edge detected, two stages suffice
  // skew between bits settles well before the load edge
  always_comb begin
    ac1_d = accumulator_output_lines;
    ac2_d = ac1_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac1_q <= '0;
      ac2_q <= '0;
    end else begin
      ac1_q <= ac1_d;
      ac2_q <= ac2_d;
    end
  end

  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction

  // core state
  logic match;
  logic flag_test_pulse;
  logic buffer_load_pulse;
  logic set_edge;
  logic flag_q;
  logic flag_d;
  logic [data_w-1:0] buf_q;
  logic [data_w-1:0] buf_d;
  logic [data_w-1:0] gated_data;
  logic test_edge;
  logic load_edge;
  logic init_edge;
  logic skip_q;
  logic skip_d;
  logic pi_q;
  logic pi_d;

  // register file and apb response
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [brbf_pkg::brbf_ev_w-1:0] ists_q;
  logic [brbf_pkg::brbf_ev_w-1:0] ists_d;
  logic [brbf_pkg::brbf_ev_w-1:0] imsk_q;
  logic [brbf_pkg::brbf_ev_w-1:0] imsk_d;
  logic irq_q;
  logic irq_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic ready_q;
  logic ready_d;
  logic err_q;
  logic err_d;
  logic [brbf_pkg::brbf_ev_w-1:0] ev;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic [brbf_pkg::brbf_ev_w-1:0] w1c;

  always_comb begin
    match = (s2_q.sel == sel_code); // [R1] [R13]
    test_edge = rise(s2_q.iop1, s3_q.iop1);
    load_edge = rise(s2_q.iop2, s3_q.iop2);
    init_edge = rise(s2_q.init, s3_q.init);
    // io pulses only act with a match, else ignored; init clears the flag without one
    flag_test_pulse = match & test_edge; // [R2] [R14]
    buffer_load_pulse = match & load_edge; // [R5] [R14]
    set_edge = rise(s2_q.flag_set, s3_q.flag_set); // [R6]
    // option select gates bus data into buffer
    gated_data = match ? ac2_q : '0; // [R4] [R10]
    // set wins over a same-cycle clear so no peripheral edge is lost
    flag_d = flag_q;
    if (buffer_load_pulse || init_edge) begin
      flag_d = 1'b0; // [R9] [R5]
    end
    if (set_edge) begin
      flag_d = 1'b1; // [R6]
    end
    buf_d = buf_q;
    if (buffer_load_pulse) begin
      buf_d = gated_data; // [R11] [R12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
      buf_q <= '0;
    end else begin
      flag_q <= flag_d;
      buf_q <= buf_d;
    end
  end

  // skip lasts one pclk, far shorter than a bus io pulse
  // pi follows flag_d so the line moves with flag_out
  always_comb begin
    skip_d = flag_test_pulse & flag_q; // [R3]
    pi_d = flag_d & ctrl_q[brbf_pkg::brbf_ctrl_pie]; // [R7]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
      pi_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
      pi_q <= pi_d;
    end
  end

  // apb slave, one wait-free access phase
  always_comb begin
    // events raised this cycle for the interrupt status register
    ev = '0;
    ev[brbf_pkg::brbf_ev_set] = set_edge;
    ev[brbf_pkg::brbf_ev_load] = buffer_load_pulse;
    ev[brbf_pkg::brbf_ev_skip] = skip_d;
    wr_acc = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    mapped = (paddr == brbf_pkg::brbf_off_ctrl) ||
      (paddr == brbf_pkg::brbf_off_stat) ||
      (paddr == brbf_pkg::brbf_off_buf) ||
      (paddr == brbf_pkg::brbf_off_ists) ||
      (paddr == brbf_pkg::brbf_off_imsk);
    ctrl_d = ctrl_q;
    imsk_d = imsk_q;
    w1c = '0;
    if (wr_acc) begin
      case (paddr)
        brbf_pkg::brbf_off_ctrl: begin
          ctrl_d = {31'h0000_0000, pwdata[brbf_pkg::brbf_ctrl_pie]};
        end
        brbf_pkg::brbf_off_ists: begin
          w1c = pwdata[brbf_pkg::brbf_ev_w-1:0];
        end
        brbf_pkg::brbf_off_imsk: begin
          imsk_d = pwdata[brbf_pkg::brbf_ev_w-1:0];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
    // hardware set beats software clear
    ists_d = (ists_q & ~w1c) | ev;
    irq_d = |(ists_d & imsk_d);
  end

  // read data captured at setup, held through the access phase
  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      case (paddr)
        brbf_pkg::brbf_off_ctrl: begin
          rdata_d = ctrl_q;
        end
        brbf_pkg::brbf_off_stat: begin
          rdata_d = '0;
          rdata_d[brbf_pkg::brbf_stat_flag] = flag_q;
          rdata_d[brbf_pkg::brbf_stat_sel] = match;
        end
        brbf_pkg::brbf_off_buf: begin
          rdata_d = {{(32-data_w){1'b0}}, buf_q};
        end
        brbf_pkg::brbf_off_ists: begin
          rdata_d = {{(32-brbf_pkg::brbf_ev_w){1'b0}}, ists_q};
        end
        brbf_pkg::brbf_off_imsk: begin
          rdata_d = {{(32-brbf_pkg::brbf_ev_w){1'b0}}, imsk_q};
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
    // no wait states: answer in the first access cycle
    ready_d = psel & ~penable;
    err_d = psel & ~penable & ~mapped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= brbf_pkg::brbf_ctrl_rst;
      ists_q <= '0;
      imsk_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ists_q <= ists_d;
      imsk_q <= imsk_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end

  // open drain: enable high means pulling the line low
  assign skip_o = 1'b0;
  assign pi_o = 1'b0;
  assign skip_oe = skip_q; // [R3]
  assign pi_oe = pi_q; // [R7]
  assign flag_out = flag_q; // [R8]
  assign buffer_out = buf_q; // [R11]
  assign irq = irq_q;
  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
endmodule

// ### verification/brbf_properties.sv
// port checker for the bus receiver buffer flag block
// assumes bind onto brbf_top, single pclk domain
`timescale 1ns/100ps
module brbf_properties #(
  parameter int data_w = 12,
  parameter logic [5:0] sel_code = 6'h30
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic [5:0] memory_buffer_bus_lines,
  input logic second_io_pulse,
  input logic init_pulse,
  input logic flag_set_in,
  input logic skip_o,
  input logic skip_oe,
  input logic pi_oe,
  input logic flag_out,
  input logic [data_w-1:0] buffer_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pi; pi_oe |-> flag_out; endproperty
  a_pi: assert property (p_pi) else $error("pi without flag");
  property p_skip; skip_oe |-> !skip_o && $past(flag_out); endproperty
  a_skip: assert property (p_skip) else $error("skip, flag clear");
  property p_skip1; skip_oe |=> !skip_oe; endproperty
  a_skip1: assert property (p_skip1) else $error("skip too long");
  property p_set; $rose(flag_set_in) |-> ##[1:6] flag_out; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clr; $rose(init_pulse) && !flag_set_in |-> ##[1:6] !flag_out;
  endproperty
  a_clr: assert property (p_clr) else $error("init no clear");
  property p_hold; !second_io_pulse [*8] |=> $stable(buffer_out); endproperty
  a_hold: assert property (p_hold) else $error("buffer moved");
  property p_nomatch;
    (memory_buffer_bus_lines != sel_code) [*8] |=> $stable(buffer_out);
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("load unaddressed");
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("apb answer late");
  c_skip: cover property (skip_oe);
  c_flag: cover property ($rose(flag_out));
  c_err: cover property (pready && pslverr);
endmodule

// ### verification/brbf_bus_model.sv
// io bus side model: address, data, pulses and peripheral set line
// assumes bench calls its tasks just after a pclk edge
`timescale 1ns/100ps
module brbf_bus_model (
  input logic pclk,
  input logic skip_o,
  input logic skip_oe,
  output logic [5:0] sel,
  output logic [11:0] dat,
  output logic [2:0] pul,
  output logic fset
);
  logic skipped;
  initial {sel, dat, pul, fset, skipped} = '0;
  // pulled-up skip line goes low only while driven
  always @(posedge pclk) if (skip_oe && !skip_o) skipped <= 1'b1;
  // code and data held well around the pulse
  task automatic op(input logic [2:0] p, input logic [5:0] a,
                    input logic [11:0] d);
    sel <= a;
    dat <= d;
    @(posedge pclk);
    skipped <= 1'b0;
    repeat (3) @(posedge pclk);
    pul <= p;
    repeat (3) @(posedge pclk);
    pul <= 3'h0;
    repeat (6) @(posedge pclk);
    sel <= ~a; // released lines no longer hold the last value
    dat <= ~d;
    @(posedge pclk);
  endtask
  task automatic raise_flag();
    fset <= 1'b1;
    repeat (8) @(posedge pclk);
    fset <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ### verification/bus_receiver_buffer_flag_tb.sv
// self-checking bench for brbf_top with io bus model and apb master
// assumes design select code left at its default
`timescale 1ns/100ps
module bus_receiver_buffer_flag_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, skip_o, skip_oe, pi_o, pi_oe, flag_out, irq, fset;
  logic [11:0] buffer_out, dat;
  logic [5:0] sel;
  logic [2:0] pul;
  int failures = 0, n_compared = 0;
  initial forever #4 pclk = ~pclk;
  brbf_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memory_buffer_bus_lines(sel), .first_io_pulse(pul[0]),
    .second_io_pulse(pul[1]), .init_pulse(pul[2]), .flag_set_in(fset),
    .accumulator_output_lines(dat), .skip_o(skip_o), .skip_oe(skip_oe),
    .pi_o(pi_o), .pi_oe(pi_oe), .flag_out(flag_out),
    .buffer_out(buffer_out), .irq(irq));
  brbf_bus_model bm_u (.pclk(pclk), .skip_o(skip_o), .skip_oe(skip_oe),
    .sel(sel), .dat(dat), .pul(pul), .fset(fset));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      failures++;
      $display("[FAIL] %0t saw %h want %h", $time, s, x);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] er, input logic ee);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // sample mid-cycle; the next rising edge completes the access
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    if (!w) chk(prdata, er);
    chk(pslverr, ee);
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) failures++;
    @(posedge pclk);
  endtask
  task automatic t_regs();
    acc(0, 8'h00, 0, 32'h1, 0);
    acc(0, 8'h10, 0, 32'h0, 0);
    acc(1, 8'h40, 32'h1, 0, 1);
    acc(0, 8'h40, 0, 32'h0, 1);
  endtask
  task automatic t_flag();
    bm_u.raise_flag();
    chk(flag_out, 1);
    chk(pi_oe, 1);
    chk({pi_o, skip_o}, 0);
    acc(1, 8'h10, 32'h1, 0, 0);
    repeat (2) @(posedge pclk);
    chk(irq, 1);
    acc(1, 8'h0c, 32'h1, 0, 0);
    acc(1, 8'h00, 32'h0, 0, 0);
    repeat (2) @(posedge pclk);
    chk({irq, pi_oe}, 0);
    acc(1, 8'h00, 32'h1, 0, 0);
  endtask
  task automatic t_bus();
    bm_u.op(3'h1, 6'h31, 12'h000);
    chk(bm_u.skipped, 0);
    bm_u.op(3'h1, 6'h30, 12'h000);
    chk({bm_u.skipped, flag_out}, 3);
    bm_u.op(3'h2, 6'h31, 12'h5a3);
    chk({flag_out, buffer_out}, 13'h1000);
    bm_u.op(3'h2, 6'h30, 12'hfff);
    chk({flag_out, buffer_out}, 13'h0fff);
    bm_u.op(3'h2, 6'h30, 12'ha5c);
    chk(buffer_out, 12'ha5c);
    bm_u.op(3'h1, 6'h30, 12'h000);
    chk(bm_u.skipped, 0);
    bm_u.raise_flag();
    bm_u.op(3'h4, 6'h00, 12'h000);
    chk(flag_out, 0);
  endtask
  task automatic end_sim();
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_flag();
    t_bus();
    end_sim();
  end
  initial begin
    #100000;
    failures++;
    end_sim();
  end
endmodule
bind brbf_top brbf_properties #(.data_w(data_w), .sel_code(sel_code)) pr_u (.*);
